/* hdl/asd_pkg.sv */
// Constants and types for the address space decoder
package asd_pkg;
   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [31:0] ASD_LOWEST_SIGNED_ADDRESS = 32'h80000000;
   localparam logic [31:0] ASD_SRAM_BYTES            = 32'h00004000;
   localparam logic [31:0] ASD_LINK_IN_BASE          = 32'h80000010;
   localparam logic [31:0] ASD_EVENT_CHANNEL         = 32'h80000020;
   localparam logic [31:0] ASD_TRAP_AREA_BASE        = 32'h80000040;
   localparam logic [31:0] ASD_TRAP_LOW_BASE         = 32'h800000c0;
   localparam logic [31:0] ASD_FIRST_FREE_USER_WORD  = 32'h80000140;
   localparam logic [31:0] ASD_PERIPH_BASE           = 32'h20000000;
   localparam logic [31:0] ASD_PERIPH_TOP            = 32'h40000000;
   localparam int          ASD_PERIPH_BLOCK_LSB      = 12;
   localparam int          ASD_BANK_LSB              = 30;
   localparam logic [3:0]  ASD_TRAP_STRUCT_LSB       = 4'h4;
   // ----------------------------------------------------------------
   // Peripheral selects and regions
   // ----------------------------------------------------------------
   localparam int          ASD_NUM_PERIPH            = 5;
   localparam logic [17:0] ASD_PERIPH_OTHER_BLOCK    = 18'h00004;
   localparam logic [3:0]  ASD_NUM_LINKS             = 4'h4;

   typedef enum logic [1:0]
   {
      ASD_TGT_EXT,
      ASD_TGT_SRAM,
      ASD_TGT_PERIPH
   } asd_target_t;

   typedef enum logic [2:0]
   {
      ASD_REG_LINK_OUT,
      ASD_REG_LINK_IN,
      ASD_REG_EVENT,
      ASD_REG_RESERVED,
      ASD_REG_TRAP_HIGH,
      ASD_REG_TRAP_LOW,
      ASD_REG_USER
   } asd_region_t;
endpackage : asd_pkg

/* hdl/asd_periph_sel.sv */
// Peripheral block select for one 4K block index
`timescale 1ns/1ps
module asd_periph_sel
#(
   parameter logic [17:0] BLOCK    = 18'h00000,
   parameter bit          OPEN_TOP = 1'b0
)
(
   // Block index of the access
   input  wire logic [17:0] blockIdx,
   // Select out
   output logic             hit
);
   // Last select covers every block from its index upward
   assign hit = OPEN_TOP ? (blockIdx >= BLOCK) : (blockIdx == BLOCK);
endmodule : asd_periph_sel

/* hdl/asd_sram_region.sv */
// Classification of an address inside the reserved low SRAM layout
`timescale 1ns/1ps
module asd_sram_region
   import asd_pkg::*;
(
   // Byte address
   input  wire logic [31:0]          addr,
   // Region, link number and trap group
   output asd_pkg::asd_region_t      region,
   output logic [1:0]                chanIdx,
   output logic [1:0]                trapGroup,
   output logic                      trapProcess
);
   // Region boundaries from the bottom of memory upward
   always_comb
   begin
      if (addr < ASD_LINK_IN_BASE)
         region = ASD_REG_LINK_OUT;
      else if (addr < ASD_EVENT_CHANNEL)
         region = ASD_REG_LINK_IN;
      else if (addr < ASD_EVENT_CHANNEL + 32'h4)
         region = ASD_REG_EVENT;
      else if (addr < ASD_TRAP_AREA_BASE)
         region = ASD_REG_RESERVED;
      else if (addr < ASD_TRAP_LOW_BASE)
         region = ASD_REG_TRAP_HIGH;
      else if (addr < ASD_FIRST_FREE_USER_WORD)
         region = ASD_REG_TRAP_LOW;
      else
         region = ASD_REG_USER;
   end

   // One word per link channel
   assign chanIdx     = addr[3:2];
   // Group takes handler (16 bytes) then trapped process (16 bytes)
   wire logic [31:0] trapOff = (addr >= ASD_TRAP_LOW_BASE) ? addr - ASD_TRAP_LOW_BASE
                                                          : addr - ASD_TRAP_AREA_BASE;
   assign trapGroup   = trapOff[6:5];
   assign trapProcess = trapOff[ASD_TRAP_STRUCT_LSB];
endmodule : asd_sram_region

/* hdl/address_space_decoder.sv */
// Address space decoder: peripheral, internal SRAM and external bank routing
// ----------------------------------------------------------------------
// Summary of operation
// - Device access in 0x20000000..0x3fffffff goes to on-chip peripherals.
// - Device access outside peripheral range is a normal memory access.
// - Ordinary loads and stores in peripheral range go to external memory.
// - Peripheral range split into 4K blocks, one peripheral each.
// - Blocks: interrupt, low-power, memory-interface, diagnostic, then others.
// - 16 Kbyte SRAM decoded from the most negative address upward.
// - SRAM wins over external memory where both cover an address.
// - External input internal_ram_off disables the internal RAM.
// - Address space split into four equal quarter banks.
// - Selected bank reported with every external access.
// - Every address maps to a bank; no out-of-range detection.
// - Word address plus byte enables for byte and part-word transfers.
// - SRAM regions: channels, traps, then user space from 0x80000140.
// - High traps from 0x80000040, low from 0x800000c0, 16-byte structures.
// - Link outputs at bottom, link inputs 0x80000010, event 0x80000020.
// - Peripherals reachable only through device-access instructions.
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module address_space_decoder
   import asd_pkg::*;
(
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   // Access request from the core
   input  wire logic                          accValid,
   input  wire logic [31:0]                   accAddr,
   input  wire logic                          accDevice,
   input  wire logic                          accWrite,
   input  wire logic [1:0]                    accSize,
   // Strap pin from board logic
   input  wire logic                          internal_ram_off,
   // Target selects
   output logic                               selPeriph,
   output logic                               selSram,
   output logic                               selExt,
   output logic [asd_pkg::ASD_NUM_PERIPH-1:0] periphSel,
   output logic [1:0]                         extBank,
   // Address and lanes toward the target
   output logic [29:0]                        wordAddr,
   output logic [3:0]                         byteEn,
   output logic                               outWrite,
   output logic [11:0]                        periphOffset,
   output logic [11:0]                        sramWordIdx,
   // Reserved-area classification
   output asd_pkg::asd_region_t               sramRegion,
   output logic [1:0]                         chanIdx,
   output logic [1:0]                         trapGroup,
   output logic                               trapProcess,
   // Half-cycle phase marker
   output logic                               phase
);
   // ----------------------------------------------------------------
   // Synchronise the pin
   // ----------------------------------------------------------------
   logic ramOffMeta;
   logic ramOffSync;

   // Two stages; only the second is read
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ramOffMeta <= 1'b0;
         ramOffSync <= 1'b0;
      end
      else
      begin
         ramOffMeta <= internal_ram_off;
         ramOffSync <= ramOffMeta;
      end
   end

   // ----------------------------------------------------------------
   // Combinational decode
   // ----------------------------------------------------------------
   logic                      inPeriphRange;
   logic                      inSram;
   logic [17:0]               blockIdx;
   logic [ASD_NUM_PERIPH-1:0] blockHit;
   asd_target_t               next_target;
   logic [3:0]                next_byteEn;
   asd_region_t               regionC;
   logic [1:0]                chanC;
   logic [1:0]                groupC;
   logic                      procC;

   // Peripheral window is the upper half of bank 0
   assign inPeriphRange = (accAddr >= ASD_PERIPH_BASE) && (accAddr < ASD_PERIPH_TOP);
   // SRAM covers 16 Kbytes from the lowest signed address
   assign inSram = (accAddr - ASD_LOWEST_SIGNED_ADDRESS) < ASD_SRAM_BYTES;
   // 4K block index inside the window; bit 29 marks the window itself, so it is dropped
   assign blockIdx = {1'b0, accAddr[28:ASD_PERIPH_BLOCK_LSB]};

   // One select per peripheral block, the last open upward
   genvar gi;
   generate
      for (gi = 0; gi < ASD_NUM_PERIPH; gi++)
      begin : g_blk
         asd_periph_sel
         #(
            .BLOCK    (18'(gi)),
            .OPEN_TOP (gi == ASD_NUM_PERIPH - 1)
         )
         u_sel
         (
            .blockIdx (blockIdx),
            .hit      (blockHit[gi])
         );
      end
   endgenerate

   // Reserved low-memory layout
   asd_sram_region u_region
   (
      .addr        (accAddr),
      .region      (regionC),
      .chanIdx     (chanC),
      .trapGroup   (groupC),
      .trapProcess (procC)
   );

   // Priority: peripheral, SRAM, external; one always wins
   always_comb
   begin
      if (accDevice && inPeriphRange)
         next_target = ASD_TGT_PERIPH;
      else if (inSram && !ramOffSync)
         next_target = ASD_TGT_SRAM;
      else
         next_target = ASD_TGT_EXT;
   end

   // Byte lanes: size 0 byte, 1 half, else word
   always_comb
   begin
      unique case (accSize)
         2'b00:   next_byteEn = 4'h1 << accAddr[1:0];
         2'b01:   next_byteEn = accAddr[1] ? 4'hc : 4'h3;
         default: next_byteEn = 4'hf;
      endcase
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------

   // Target selects, held low while no access is offered
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         selPeriph <= 1'b0;
         selSram   <= 1'b0;
         selExt    <= 1'b0;
         periphSel <= '0;
      end
      else
      begin
         selPeriph <= accValid && (next_target == ASD_TGT_PERIPH);
         selSram   <= accValid && (next_target == ASD_TGT_SRAM);
         selExt    <= accValid && (next_target == ASD_TGT_EXT);
         periphSel <= (accValid && next_target == ASD_TGT_PERIPH) ? blockHit : '0;
      end
   end

   // Address, bank and lanes travel with every access
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         extBank      <= 2'h0;
         wordAddr     <= 30'h0;
         byteEn       <= 4'h0;
         outWrite     <= 1'b0;
         periphOffset <= 12'h000;
         sramWordIdx  <= 12'h000;
      end
      else
      begin
         extBank      <= accAddr[31:ASD_BANK_LSB];
         wordAddr     <= accAddr[31:2];
         byteEn       <= accValid ? next_byteEn : 4'h0;
         outWrite     <= accValid && accWrite;
         periphOffset <= accAddr[ASD_PERIPH_BLOCK_LSB-1:0];
         sramWordIdx  <= accAddr[13:2];
      end
   end

   // Reserved-area tags for the core's system state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sramRegion  <= ASD_REG_LINK_OUT;
         chanIdx     <= 2'h0;
         trapGroup   <= 2'h0;
         trapProcess <= 1'b0;
      end
      else
      begin
         // Only meaningful while selSram is high
         sramRegion  <= regionC;
         chanIdx     <= chanC;
         trapGroup   <= groupC;
         trapProcess <= procC;
      end
   end

   // Phase toggles each rising edge: two phases make one cycle of timing
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         phase <= 1'b0;
      else
         phase <= ~phase;
   end
endmodule : address_space_decoder

/* testbench/asd_chk.sv */
// Port checker for the address space decoder
`timescale 1ns/1ps
module asd_chk
   import asd_pkg::*;
(
   // Clock and reset
   input wire logic                      ref_clk,
   input wire logic                      rst_n,
   // Request side
   input wire logic                      accValid,
   input wire logic [31:0]               accAddr,
   input wire logic                      accDevice,
   input wire logic [1:0]                accSize,
   input wire logic                      internal_ram_off,
   // Decoded side
   input wire logic                      selPeriph,
   input wire logic                      selSram,
   input wire logic                      selExt,
   input wire logic [ASD_NUM_PERIPH-1:0] periphSel,
   input wire logic [1:0]                extBank,
   input wire logic [29:0]               wordAddr,
   input wire logic [3:0]                byteEn,
   input wire logic                      phase
);
   logic       inPer;
   logic       inSram;
   logic [2:0] offHist;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Range flags of the offered address
   assign inPer  = accAddr >= ASD_PERIPH_BASE && accAddr < ASD_PERIPH_TOP;
   assign inSram = accAddr[31:14] == ASD_LOWEST_SIGNED_ADDRESS[31:14];
   // Pin history, so the two-flop sync lag never makes a check ambiguous
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n) offHist <= 3'h0;
      else offHist <= {offHist[1:0], internal_ram_off};
   end
   function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] s);
      if (s == 2'h0) return 4'h1 << a;
      if (s == 2'h1) return a[1] ? 4'hc : 4'h3;
      return 4'hf;
   endfunction : lanes
   function automatic logic [4:0] blk(input logic [31:0] a);
      return (a[28:14] != 15'h0) ? 5'h10 : 5'h01 << a[13:12];
   endfunction : blk
   per_route_a: assert property (accValid && accDevice && inPer |=> selPeriph &&
      periphSel == blk($past(accAddr))) else $error("peripheral route wrong");
   dev_mem_a: assert property (accValid && accDevice && !inPer |=>
      !selPeriph && periphSel == 5'h00) else $error("device access hit peripheral");
   ld_ext_a: assert property (accValid && !accDevice && inPer |=> selExt && !selPeriph)
      else $error("plain access in peripheral range not external");
   sram_win_a: assert property (accValid && inSram && !(|{offHist, internal_ram_off})
      |=> selSram && !selExt) else $error("sram not selected");
   ram_off_a: assert property (accValid && &{offHist, internal_ram_off} |=> !selSram)
      else $error("sram selected while disabled");
   one_sel_a: assert property ($onehot0({selPeriph, selSram, selExt}) &&
      ((|{selPeriph, selSram, selExt}) == $past(accValid))) else $error("select count");
   bank_a: assert property (accValid |=> extBank == $past(accAddr[31:30]))
      else $error("bank wrong");
   lane_a: assert property (accValid |=> wordAddr == $past(accAddr[31:2]) &&
      byteEn == lanes($past(accAddr[1:0]), $past(accSize))) else $error("lanes wrong");
   phase_a: assert property ($past(rst_n) |-> phase != $past(phase))
      else $error("phase stuck");
endmodule : asd_chk

/* testbench/asd_core_model.sv */
// Behavioural processor core that offers accesses to the decoder
`timescale 1ns/1ps
module asd_core_model
(
   // Clock
   input wire logic    ref_clk,
   // Access toward the decoder
   output logic        accValid,
   output logic [31:0] accAddr,
   output logic        accDevice,
   output logic        accWrite,
   output logic [1:0]  accSize,
   output logic        internal_ram_off
);
   // Idle at time zero, internal RAM enabled
   initial
   begin
      accValid = 1'b0;
      accAddr = 32'h0;
      accDevice = 1'b0;
      accWrite = 1'b0;
      accSize = 2'h0;
      internal_ram_off = 1'b0;
   end
   // One access per edge, byte or part-word lanes chosen by size
   task automatic issue(input logic [31:0] a, input logic d, w, input logic [1:0] s);
      @(posedge ref_clk);
      accValid <= 1'b1;
      accAddr <= a;
      accDevice <= d;
      accWrite <= w;
      accSize <= s;
   endtask : issue
   // Released lines flip so a stale address never looks valid
   task automatic rest;
      @(posedge ref_clk);
      accValid <= 1'b0;
      accAddr <= ~accAddr;
      accDevice <= ~accDevice;
   endtask : rest
   // Board strap that switches the internal RAM off
   task automatic ramOff(input logic v);
      @(posedge ref_clk);
      internal_ram_off <= v;
   endtask : ramOff
endmodule : asd_core_model

/* testbench/address_space_decoder_tb.sv */
// Self-checking testbench for the address space decoder
`timescale 1ns/1ps
module address_space_decoder_tb;
   import asd_pkg::*;
   logic ref_clk, rst_n, accValid, accDevice, accWrite, ramOff;
   logic selPeriph, selSram, selExt, outWrite, trapProcess, phase;
   logic [31:0] accAddr;
   logic [1:0]  accSize, extBank, chanIdx, trapGroup;
   logic [4:0]  periphSel;
   logic [29:0] wordAddr;
   logic [3:0]  byteEn;
   logic [11:0] periphOffset, sramWordIdx;
   asd_region_t sramRegion;
   int          errorCnt = 0;
   int          nTests = 0;
   address_space_decoder i_address_space_decoder (.ref_clk, .rst_n, .accValid, .accAddr,
      .accDevice, .accWrite, .accSize, .internal_ram_off(ramOff), .selPeriph, .selSram,
      .selExt, .periphSel, .extBank, .wordAddr, .byteEn, .outWrite, .periphOffset,
      .sramWordIdx, .sramRegion, .chanIdx, .trapGroup, .trapProcess, .phase);
   asd_core_model i_asd_core_model (.ref_clk, .accValid, .accAddr, .accDevice, .accWrite,
      .accSize, .internal_ram_off(ramOff));
   // Free-running 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // Offer one access, then look after the answering edge
   task automatic acc(input logic [31:0] a, input logic d, input logic [1:0] s,
                      input logic w = 1'b1);
      i_asd_core_model.issue(a, d, w, s);
      @(posedge ref_clk);
      #1;
   endtask : acc
   task automatic tPeriph;
      for (int i = 0; i < 5; i++)
      begin
         acc(32'h20000004 + i * 32'h1000, 1'b1, 2'h2);
         chk(selPeriph, 1'b1);
         chk(periphSel, 5'h01 << i);
         chk(periphOffset, 12'h004);
      end
      acc(32'h3ffffffc, 1'b1, 2'h2);
      chk(periphSel, 5'h10);
      acc(32'h40000000, 1'b1, 2'h2);
      chk({selPeriph, selExt, extBank}, 4'h5);
      acc(32'h20001000, 1'b0, 2'h2);
      chk({selPeriph, selExt, extBank}, 4'h4);
   endtask : tPeriph
   task automatic tSram;
      logic [31:0] a [8] = '{32'h80000000, 32'h80000014, 32'h80000020, 32'h80000024,
         32'h80000040, 32'h800000f0, 32'h80000140, 32'h80003ffc};
      asd_region_t r [8] = '{ASD_REG_LINK_OUT, ASD_REG_LINK_IN, ASD_REG_EVENT,
         ASD_REG_RESERVED, ASD_REG_TRAP_HIGH, ASD_REG_TRAP_LOW, ASD_REG_USER, ASD_REG_USER};
      for (int i = 0; i < 8; i++)
      begin
         acc(a[i], 1'b0, 2'h2);
         chk({selSram, selExt}, 2'h2);
         chk(sramRegion, r[i]);
      end
      chk(sramWordIdx, 12'hfff);
      acc(32'h800000f0, 1'b0, 2'h2);
      chk({trapGroup, trapProcess}, 3'h3);
      acc(32'h80000014, 1'b0, 2'h2);
      chk(chanIdx, 2'h1);
      acc(32'h80004000, 1'b0, 2'h2);
      chk({selSram, selExt, extBank}, 4'h6);
   endtask : tSram
   task automatic tRamOff;
      for (int v = 1; v >= 0; v--)
      begin
         i_asd_core_model.ramOff(v[0]);
         repeat (3) @(posedge ref_clk);
         acc(32'h80000150, 1'b0, 2'h2);
         chk({selSram, selExt}, v[0] ? 2'h1 : 2'h2);
      end
   endtask : tRamOff
   task automatic tLanes;
      for (int s = 0; s < 3; s++)
         for (int k = 0; k < 4; k++)
         begin
            acc(32'h00000100 + k, 1'b0, s[1:0], k[0]);
            chk(byteEn, s == 0 ? 4'h1 << k : s == 1 ? (k > 1 ? 4'hc : 4'h3) : 4'hf);
            chk({wordAddr, outWrite}, {30'h40, k[0]});
         end
      for (int q = 0; q < 4; q++)
      begin
         acc({q[1:0], 30'h10}, 1'b0, 2'h2);
         chk(extBank, q[1:0]);
      end
   endtask : tLanes
   task automatic tPhase;
      logic p;
      p = phase;
      @(posedge ref_clk);
      #1;
      chk(phase, !p);
   endtask : tPhase
   // Idle lines, then a mid-run reset and a fresh access after it
   task automatic tIdle;
      i_asd_core_model.rest;
      @(posedge ref_clk);
      #1;
      chk({selPeriph, selSram, selExt, byteEn, outWrite}, 8'h00);
      rst_n <= 1'b0;
      #1;
      chk({phase, extBank, periphOffset}, 15'h0000);
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      acc(32'h20002000, 1'b1, 2'h2);
      chk(periphSel, 5'h04);
   endtask : tIdle
   // Reset, then the scenarios in turn
   initial
   begin
      rst_n = 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      tPeriph;
      tSram;
      tRamOff;
      tLanes;
      tPhase;
      tIdle;
      conclude;
   end
   // Watchdog well beyond the roughly 110 cycles the scenarios need
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      errorCnt++;
      conclude;
   end
endmodule : address_space_decoder_tb
bind address_space_decoder asd_chk i_asd_chk (.ref_clk, .rst_n, .accValid, .accAddr,
   .accDevice, .accSize, .internal_ram_off, .selPeriph, .selSram, .selExt, .periphSel,
   .extBank, .wordAddr, .byteEn, .phase);
